/* File: cpa_pkg.sv */
/*
 * Constants and types shared by the configuration port arbiter.
 * Assumes a 40 MHz configuration clock and a 32-bit control register one.
 */
package cpa_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_PS   = 25000;
	localparam int unsigned PROG_MIN_NS     = 50;
	localparam int unsigned PROG_MIN_CYC    =
		(PROG_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CLEAR_CYC       = 64;

	// ==========================================================
	// Control register one fields
	localparam int unsigned CR1_W           = 32;
	localparam int unsigned CR1_CLK_POL_BIT = 20;
	localparam int unsigned CR1_EBR_ERA_BIT = 4;

	// ==========================================================
	// Reset values
	localparam logic        BOOT_ABORT_RST  = 1'b0;
	localparam logic        TGT_ABORT_RST   = 1'b0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_CLEAR     = 3'b000,
		ST_CTRL_BOOT = 3'b001,
		ST_CTRL_IDLE = 3'b010,
		ST_TGT_WAIT  = 3'b011,
		ST_TGT_CFG   = 3'b100,
		ST_USER      = 3'b101
	} cpa_state_t;

	typedef enum logic [1:0] {
		OWN_NONE = 2'b00,
		OWN_JTAG = 2'b01,
		OWN_SPI  = 2'b10
	} cpa_owner_t;

endpackage

/* File: cpa_pin_if.sv */
/*
 * Conditioned pin levels passed from the pin filter to the arbiter.
 * Assumes both ends run on the configuration clock.
 */
`timescale 1ns/1ps
interface cpa_pin_if;
	logic prog_low;
	logic mode_high;

	modport src (output prog_low, output mode_high);
	modport dst (input prog_low, input mode_high);
endinterface

/* File: cpa_pin_filter.sv */
/*
 * Synchronisers for the program and mode-select pins, plus the
 * minimum-width qualifier on the program pin.
 * Assumes pins are asynchronous to CLK; RST is synchronous, active high.
 */
`timescale 1ns/1ps
module cpa_pin_filter #(
	parameter int unsigned MIN_CYC = cpa_pkg::PROG_MIN_CYC
) (
	input  wire logic CLK,
	input  wire logic RST,
	input  wire logic PROG_N_PIN,
	input  wire logic MODE_PIN,
	cpa_pin_if.src    pin
);
	localparam int unsigned CW = $clog2(MIN_CYC + 1);

	logic          prog_s1_r;
	logic          prog_s2_r;
	logic          mode_s1_r;
	logic          mode_s2_r;
	logic [CW-1:0] low_cnt_r;
	logic          prog_low_r;

	// ==========================================================
	// Synchronisers
	always_ff @(posedge CLK) begin
		if (RST) begin
			prog_s1_r <= 1'b1;
			prog_s2_r <= 1'b1;
			mode_s1_r <= 1'b0;
			mode_s2_r <= 1'b0;
		end else begin
			prog_s1_r <= PROG_N_PIN;
			prog_s2_r <= prog_s1_r;
			mode_s1_r <= MODE_PIN;
			mode_s2_r <= mode_s1_r;
		end
	end

	// ==========================================================
	// Width qualifier: short glitches never count as a request
	always_ff @(posedge CLK) begin
		if (RST) begin
			low_cnt_r  <= '0;
			prog_low_r <= 1'b0;
		end else if (prog_s2_r) begin
			low_cnt_r  <= '0;
			prog_low_r <= 1'b0;
		end else if (low_cnt_r < CW'(MIN_CYC)) begin
			low_cnt_r  <= low_cnt_r + CW'(1);
			prog_low_r <= (low_cnt_r == CW'(MIN_CYC - 1));
		end
	end

	assign pin.prog_low  = prog_low_r;
	assign pin.mode_high = mode_s2_r;
endmodule

/* File: cpa_arbiter.sv */
/*
 * Configuration port arbiter: clear-down, boot mode choice, port
 * ownership, abort handling, program pin and clock-pin pull control.
 * Assumes a 40 MHz clock, RST as power-on reset, and one-cycle pulses
 * on the command and request inputs from logic on the same clock.
 */
`timescale 1ns/1ps
module cpa_arbiter #(
	parameter int unsigned CLEAR_CYC = cpa_pkg::CLEAR_CYC
) (
	input  wire logic                     CLK,
	input  wire logic                     RST,
	input  wire logic                     PROG_N_PIN,
	input  wire logic                     BOOT_MODE_SELECT,
	input  wire logic                     REFRESH_CMD,
	input  wire logic                     JTAG_PORT_REQ,
	input  wire logic                     TGT_SPI_PORT_REQ,
	input  wire logic                     PORT_RELEASE,
	input  wire logic                     JTAG_PROG_BUSY,
	input  wire logic                     CFG_DONE,
	input  wire logic                     TGT_SPI_PERSIST,
	input  wire logic [cpa_pkg::CR1_W-1:0] CONTROL_REGISTER_ONE,
	output logic                          CLEARDOWN_ACTIVE,
	output logic                          ERASE_BLOCK_RAM,
	output logic                          INIT_STATUS_N_OE,
	output logic                          DONE_OE,
	output logic                          CTRL_BOOT_ACTIVE,
	output logic                          TGT_MODE,
	output logic                          USER_MODE,
	output logic                          GRANT_JTAG,
	output logic                          GRANT_TGT_SPI,
	output logic                          TGT_SPI_GPIO,
	output logic                          BOOT_ABORTED,
	output logic                          TGT_ABORTED,
	output logic                          SCLK_PULL_UP,
	output logic                          MCLK_PULL_UP,
	output logic                          CONTROLLER_CLOCK_INVERTED_PULL_UP
);
	localparam int unsigned CW = $clog2(CLEAR_CYC + 1);

	cpa_pin_if pin ();

	cpa_pkg::cpa_state_t state_r;
	cpa_pkg::cpa_state_t state_nxt;
	cpa_pkg::cpa_owner_t owner_r;
	cpa_pkg::cpa_owner_t owner_nxt;
	logic [CW-1:0]       clr_cnt_r;
	logic                prog_hit;
	logic                restart;
	logic                clr_done;
	logic                boot_abort_set;
	logic                tgt_abort_set;
	logic                clk_pol;
	logic                ebr_opt;

	// ==========================================================
	// Pin conditioning
	cpa_pin_filter u_filter (
		.CLK        (CLK),
		.RST        (RST),
		.PROG_N_PIN (PROG_N_PIN),
		.MODE_PIN   (BOOT_MODE_SELECT),
		.pin        (pin.src)
	);

	// ==========================================================
	// Restart sources
	// Program pin is masked, not latched, during JTAG programming:
	// a pulse that ends before the JTAG sequence finishes is lost.
	assign prog_hit = pin.prog_low & ~JTAG_PROG_BUSY;
	assign restart  = REFRESH_CMD | prog_hit;
	assign clr_done = (clr_cnt_r == CW'(CLEAR_CYC - 1));
	assign clk_pol  = CONTROL_REGISTER_ONE[cpa_pkg::CR1_CLK_POL_BIT];
	assign ebr_opt  = CONTROL_REGISTER_ONE[cpa_pkg::CR1_EBR_ERA_BIT];

	// ==========================================================
	// Clear-down timer
	always_ff @(posedge CLK) begin
		if (RST) begin
			clr_cnt_r <= '0;
		end else if (state_r != cpa_pkg::ST_CLEAR || restart) begin
			clr_cnt_r <= '0;
		end else if (!clr_done) begin
			clr_cnt_r <= clr_cnt_r + CW'(1);
		end
	end

	// ==========================================================
	// Next state and port ownership
	always_comb begin
		state_nxt      = state_r;
		owner_nxt      = owner_r;
		boot_abort_set = 1'b0;
		tgt_abort_set  = 1'b0;
		if (restart) begin
			// Level held low keeps the device in clear-down
			state_nxt = cpa_pkg::ST_CLEAR;
			owner_nxt = cpa_pkg::OWN_NONE;
		end else begin
			unique case (state_r)
				cpa_pkg::ST_CLEAR: begin
					if (clr_done) begin
						if (pin.mode_high) begin
							state_nxt = cpa_pkg::ST_CTRL_BOOT;
						end else begin
							state_nxt = cpa_pkg::ST_TGT_WAIT;
						end
					end
				end
				cpa_pkg::ST_CTRL_BOOT: begin
					if (!pin.mode_high) begin
						state_nxt      = cpa_pkg::ST_TGT_WAIT;
						boot_abort_set = 1'b1;
					end else if (CFG_DONE) begin
						state_nxt = cpa_pkg::ST_USER;
					end
				end
				cpa_pkg::ST_CTRL_IDLE: begin
					// No boot from here; only a refresh or a program pin pulse restarts one
					if (!pin.mode_high) begin
						state_nxt = cpa_pkg::ST_TGT_WAIT;
					end
				end
				cpa_pkg::ST_TGT_WAIT: begin
					if (pin.mode_high) begin
						state_nxt = cpa_pkg::ST_CTRL_IDLE;
					end else if (JTAG_PORT_REQ) begin
						state_nxt = cpa_pkg::ST_TGT_CFG;
						owner_nxt = cpa_pkg::OWN_JTAG;
					end else if (TGT_SPI_PORT_REQ) begin
						state_nxt = cpa_pkg::ST_TGT_CFG;
						owner_nxt = cpa_pkg::OWN_SPI;
					end
				end
				cpa_pkg::ST_TGT_CFG: begin
					if (pin.mode_high) begin
						state_nxt     = cpa_pkg::ST_CTRL_IDLE;
						owner_nxt     = cpa_pkg::OWN_NONE;
						tgt_abort_set = 1'b1;
					end else if (CFG_DONE) begin
						state_nxt = cpa_pkg::ST_USER;
					end
				end
				cpa_pkg::ST_USER: begin
					// Mode pin is not consulted here
					if (PORT_RELEASE) begin
						owner_nxt = cpa_pkg::OWN_NONE;
					end else if (owner_r == cpa_pkg::OWN_NONE) begin
						if (JTAG_PORT_REQ) begin
							owner_nxt = cpa_pkg::OWN_JTAG;
						end else if (TGT_SPI_PORT_REQ &&
							TGT_SPI_PERSIST) begin
							owner_nxt = cpa_pkg::OWN_SPI;
						end
					end
				end
				default: begin
					state_nxt = cpa_pkg::ST_CLEAR;
					owner_nxt = cpa_pkg::OWN_NONE;
				end
			endcase
		end
	end

	// ==========================================================
	// State registers; power-on reset enters clear-down
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= cpa_pkg::ST_CLEAR;
			owner_r <= cpa_pkg::OWN_NONE;
		end else begin
			state_r <= state_nxt;
			owner_r <= owner_nxt;
		end
	end

	// ==========================================================
	// Abort status: a restart wins over a new abort and wipes the flag
	always_ff @(posedge CLK) begin
		if (RST) begin
			BOOT_ABORTED <= cpa_pkg::BOOT_ABORT_RST;
		end else begin
			if (boot_abort_set) begin
				BOOT_ABORTED <= 1'b1;
			end else if (restart) begin
				BOOT_ABORTED <= 1'b0;
			end
		end
	end

	// Kept until a restart so the host can tell why nothing booted
	always_ff @(posedge CLK) begin
		if (RST) begin
			TGT_ABORTED <= cpa_pkg::TGT_ABORT_RST;
		end else begin
			if (tgt_abort_set) begin
				TGT_ABORTED <= 1'b1;
			end else if (restart) begin
				TGT_ABORTED <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Clear-down outputs
	always_ff @(posedge CLK) begin
		if (RST) begin
			CLEARDOWN_ACTIVE <= 1'b1;
		end else begin
			CLEARDOWN_ACTIVE <= (state_nxt == cpa_pkg::ST_CLEAR);
		end
	end

	// Block RAM wipe only when the option bit asks for it
	always_ff @(posedge CLK) begin
		if (RST) begin
			ERASE_BLOCK_RAM <= 1'b0;
		end else begin
			ERASE_BLOCK_RAM <= (state_nxt == cpa_pkg::ST_CLEAR) &&
				ebr_opt;
		end
	end

	// Done pin is pulled low in step with the init pin
	always_ff @(posedge CLK) begin
		if (RST) begin
			INIT_STATUS_N_OE <= 1'b1;
			DONE_OE          <= 1'b1;
		end else begin
			INIT_STATUS_N_OE <= (state_nxt == cpa_pkg::ST_CLEAR);
			DONE_OE          <= (state_nxt == cpa_pkg::ST_CLEAR);
		end
	end

	// ==========================================================
	// Mode and ownership outputs
	always_ff @(posedge CLK) begin
		if (RST) begin
			CTRL_BOOT_ACTIVE <= 1'b0;
			TGT_MODE         <= 1'b0;
			USER_MODE        <= 1'b0;
		end else begin
			CTRL_BOOT_ACTIVE <= (state_nxt == cpa_pkg::ST_CTRL_BOOT);
			TGT_MODE         <= (state_nxt == cpa_pkg::ST_TGT_WAIT) ||
				(state_nxt == cpa_pkg::ST_TGT_CFG);
			USER_MODE        <= (state_nxt == cpa_pkg::ST_USER);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			GRANT_JTAG    <= 1'b0;
			GRANT_TGT_SPI <= 1'b0;
		end else begin
			GRANT_JTAG    <= (owner_nxt == cpa_pkg::OWN_JTAG);
			GRANT_TGT_SPI <= (owner_nxt == cpa_pkg::OWN_SPI);
		end
	end

	// Without persist the target serial pins are lost to reprogramming
	always_ff @(posedge CLK) begin
		if (RST) begin
			TGT_SPI_GPIO <= 1'b0;
		end else begin
			TGT_SPI_GPIO <= (state_nxt == cpa_pkg::ST_USER) &&
				!TGT_SPI_PERSIST;
		end
	end

	// ==========================================================
	// Weak pulls on the clock pins
	always_ff @(posedge CLK) begin
		if (RST) begin
			SCLK_PULL_UP <= 1'b0;
			MCLK_PULL_UP <= 1'b0;
		end else begin
			SCLK_PULL_UP <= clk_pol;
			MCLK_PULL_UP <= clk_pol;
		end
	end

	// Inverted clock pin idles opposite so the pair never floats equal
	always_ff @(posedge CLK) begin
		if (RST) begin
			CONTROLLER_CLOCK_INVERTED_PULL_UP <= 1'b1;
		end else begin
			CONTROLLER_CLOCK_INVERTED_PULL_UP <= ~clk_pol;
		end
	end
endmodule

/* File: cpa_arbiter_sva.sv */
/* Port checker for the configuration port arbiter.
 * Assumes it is bound to cpa_arbiter and sees only its ports. */
`timescale 1ns/1ps
module cpa_arbiter_sva (
	input wire logic                      CLK,
	input wire logic                      RST,
	input wire logic                      PROG_N_PIN,
	input wire logic                      BOOT_MODE_SELECT,
	input wire logic                      REFRESH_CMD,
	input wire logic                      JTAG_PROG_BUSY,
	input wire logic [cpa_pkg::CR1_W-1:0] CONTROL_REGISTER_ONE,
	input wire logic                      CLEARDOWN_ACTIVE,
	input wire logic                      ERASE_BLOCK_RAM,
	input wire logic                      INIT_STATUS_N_OE,
	input wire logic                      DONE_OE,
	input wire logic                      CTRL_BOOT_ACTIVE,
	input wire logic                      TGT_MODE,
	input wire logic                      USER_MODE,
	input wire logic                      GRANT_JTAG,
	input wire logic                      GRANT_TGT_SPI,
	input wire logic                      BOOT_ABORTED,
	input wire logic                      TGT_ABORTED,
	input wire logic                      SCLK_PULL_UP,
	input wire logic                      MCLK_PULL_UP,
	input wire logic                      CONTROLLER_CLOCK_INVERTED_PULL_UP
);
	// ==========================================================
	// Assertions
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	a_pull_follow: assert property (!$past(RST) |->
		SCLK_PULL_UP ==
		$past(CONTROL_REGISTER_ONE[cpa_pkg::CR1_CLK_POL_BIT]) &&
		MCLK_PULL_UP == SCLK_PULL_UP) else $error("Clock pull wrong");
	a_pull_inverse: assert property (CONTROLLER_CLOCK_INVERTED_PULL_UP != SCLK_PULL_UP)
		else $error("Inverted clock pull wrong");
	a_done_init: assert property (DONE_OE == INIT_STATUS_N_OE)
		else $error("Done and init differ");
	a_refresh_clear: assert property (REFRESH_CMD |=>
		CLEARDOWN_ACTIVE && DONE_OE && !GRANT_JTAG && !GRANT_TGT_SPI)
		else $error("Refresh missed");
	a_ram_option: assert property (ERASE_BLOCK_RAM |-> CLEARDOWN_ACTIVE)
		else $error("Block RAM erase outside clear");
	a_mode_single: assert property (CLEARDOWN_ACTIVE ||
		!(CTRL_BOOT_ACTIVE && TGT_MODE)) else $error("Two modes");
	a_boot_abort: assert property (CTRL_BOOT_ACTIVE &&
		!BOOT_MODE_SELECT |-> ##[1:4] ((BOOT_ABORTED && TGT_MODE) ||
		CLEARDOWN_ACTIVE || USER_MODE)) else $error("Boot not aborted");
	a_tgt_abort: assert property (TGT_MODE && GRANT_JTAG &&
		BOOT_MODE_SELECT |-> ##[1:4] ((TGT_ABORTED && !GRANT_JTAG &&
		!CTRL_BOOT_ACTIVE) || CLEARDOWN_ACTIVE || USER_MODE))
		else $error("Target not aborted");
	a_grant_single: assert property (!(GRANT_JTAG && GRANT_TGT_SPI))
		else $error("Two owners");
	a_jtag_mask: assert property (!CLEARDOWN_ACTIVE &&
		JTAG_PROG_BUSY && !REFRESH_CMD |=> !CLEARDOWN_ACTIVE)
		else $error("Program pin not masked");
	a_prog_restart: assert property ((!PROG_N_PIN &&
		!JTAG_PROG_BUSY) [*6] |=> CLEARDOWN_ACTIVE)
		else $error("Program pin missed");

	c_boot_abort: cover property (BOOT_ABORTED && TGT_MODE);
	c_tgt_abort: cover property (TGT_ABORTED);
	c_user_spi: cover property (USER_MODE && GRANT_TGT_SPI);
endmodule

bind cpa_arbiter cpa_arbiter_sva i_sva (.CLK(CLK), .RST(RST),
	.PROG_N_PIN(PROG_N_PIN), .BOOT_MODE_SELECT(BOOT_MODE_SELECT),
	.REFRESH_CMD(REFRESH_CMD), .JTAG_PROG_BUSY(JTAG_PROG_BUSY),
	.CONTROL_REGISTER_ONE(CONTROL_REGISTER_ONE),
	.CLEARDOWN_ACTIVE(CLEARDOWN_ACTIVE), .ERASE_BLOCK_RAM(ERASE_BLOCK_RAM),
	.INIT_STATUS_N_OE(INIT_STATUS_N_OE), .DONE_OE(DONE_OE),
	.CTRL_BOOT_ACTIVE(CTRL_BOOT_ACTIVE), .TGT_MODE(TGT_MODE),
	.USER_MODE(USER_MODE), .GRANT_JTAG(GRANT_JTAG),
	.GRANT_TGT_SPI(GRANT_TGT_SPI), .BOOT_ABORTED(BOOT_ABORTED),
	.TGT_ABORTED(TGT_ABORTED), .SCLK_PULL_UP(SCLK_PULL_UP),
	.MCLK_PULL_UP(MCLK_PULL_UP), .CONTROLLER_CLOCK_INVERTED_PULL_UP(CONTROLLER_CLOCK_INVERTED_PULL_UP));

/* File: cpa_host_model.sv */
/* Host driving the program pin with a pulse of chosen width.
 * Assumes fire is a one-cycle pulse from the bench on CLK. */
`timescale 1ns/1ps
module cpa_host_model (
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic [3:0] width,
	input  wire logic       init_low,
	output logic            prog_n_pin
);
	// ==========================================================
	// Pulse timer
	logic [3:0] cnt_r = 4'h0;

	// No falling edge while the device initialises
	always_ff @(posedge clk) begin
		if (fire && !init_low) begin
			cnt_r <= width;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	// Released pin sits at the weak pull-up level
	assign prog_n_pin = (cnt_r == 4'h0);
endmodule

/* File: config_port_arbiter_bench.sv */
/* Self-checking bench for the configuration port arbiter.
 * Assumes a short clear-down; host model drives the program pin. */
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("Error %0t got %h exp %h", $time, a, e); end end
module config_port_arbiter_bench;
	logic        CLK = 1'b0, RST = 1'b1, MODE = 1'b1, REFRESH_CMD = 1'b0;
	logic        JREQ = 1'b0, SREQ = 1'b0, REL = 1'b0, BUSY = 1'b0;
	logic        CFG_DONE = 1'b0, PERSIST = 1'b0, fire = 1'b0;
	logic [3:0]  width = 4'h0;
	logic [31:0] CR1 = 32'h0;
	logic        PROG_N, CLR, ERA, INIT, DONE, BOOT, TGT, USER, GJ, GS, GPIO;
	logic        BA, TA, SPU, MPU, MNPU;
	int          failures = 0, checks = 0;
	wire  [6:0]  st = {BOOT, TGT, USER, GJ, GS, BA, TA};

	always #12.5 CLK = ~CLK;

	cpa_host_model i_host (.clk(CLK), .fire(fire), .width(width),
		.init_low(INIT), .prog_n_pin(PROG_N));
	cpa_arbiter #(.CLEAR_CYC(4)) i_dut (.CLK(CLK), .RST(RST),
		.PROG_N_PIN(PROG_N), .BOOT_MODE_SELECT(MODE), .REFRESH_CMD(REFRESH_CMD),
		.JTAG_PORT_REQ(JREQ), .TGT_SPI_PORT_REQ(SREQ), .PORT_RELEASE(REL),
		.JTAG_PROG_BUSY(BUSY), .CFG_DONE(CFG_DONE), .TGT_SPI_PERSIST(PERSIST),
		.CONTROL_REGISTER_ONE(CR1), .CLEARDOWN_ACTIVE(CLR),
		.ERASE_BLOCK_RAM(ERA), .INIT_STATUS_N_OE(INIT), .DONE_OE(DONE),
		.CTRL_BOOT_ACTIVE(BOOT), .TGT_MODE(TGT), .USER_MODE(USER),
		.GRANT_JTAG(GJ), .GRANT_TGT_SPI(GS), .TGT_SPI_GPIO(GPIO),
		.BOOT_ABORTED(BA), .TGT_ABORTED(TA), .SCLK_PULL_UP(SPU),
		.MCLK_PULL_UP(MPU), .CONTROLLER_CLOCK_INVERTED_PULL_UP(MNPU));

	// ==========================================================
	// Tasks
	task automatic complete_run();
		if (failures == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	// Bounded wait for the end of clear-down, then the state settles
	task automatic wait_cd();
		int i;
		for (i = 0; i < 100 && CLR !== 1'b0; i++) cyc(1);
		if (i == 100) begin
			failures++;
			complete_run();
		end
		cyc(2);
	endtask
	task automatic prog(input logic [3:0] w);
		@(posedge CLK) fire <= 1'b1;
		width <= w;
		@(posedge CLK) fire <= 1'b0;
		cyc(8);
	endtask

	// ==========================================================
	// Sequence; m holds the model's expected state vector
	initial begin : main
		logic [6:0] m;
		void'($urandom(67));
		cyc(12);
		@(posedge CLK) RST <= 1'b0;
		CR1 <= $urandom();
		cyc(1);
		`CMP(ERA, CR1[4]);
		wait_cd();
		m = 7'h40;
		`CMP(st, m);
		repeat (8) begin
			@(posedge CLK) CR1 <= $urandom();
			cyc(1);
			`CMP(SPU, CR1[20]);
			`CMP(MPU, CR1[20]);
			`CMP(MNPU, ~CR1[20]);
		end
		@(posedge CLK) MODE <= 1'b0;
		cyc(5);
		m = 7'h22;
		`CMP(st, m);
		@(posedge CLK) REFRESH_CMD <= 1'b1;
		@(posedge CLK) REFRESH_CMD <= 1'b0;
		#1 `CMP({CLR, INIT, DONE}, 3'h7);
		wait_cd();
		m = 7'h20;
		`CMP(st, m);
		@(posedge CLK) JREQ <= 1'b1;
		SREQ <= 1'b1;
		@(posedge CLK) JREQ <= 1'b0;
		SREQ <= 1'b0;
		#1 m = 7'h28;
		`CMP(st, m);
		@(posedge CLK) MODE <= 1'b1;
		cyc(8);
		m = 7'h01;
		`CMP(st, m);
		@(posedge CLK) BUSY <= 1'b1;
		prog(4'h6);
		`CMP(CLR, 1'b0);
		@(posedge CLK) BUSY <= 1'b0;
		prog(4'h1);
		`CMP(CLR, 1'b0);
		prog(4'h6);
		wait_cd();
		m = 7'h40;
		`CMP(st, m);
		@(posedge CLK) CFG_DONE <= 1'b1;
		MODE <= 1'b0;
		@(posedge CLK) CFG_DONE <= 1'b0;
		SREQ <= 1'b1;
		@(posedge CLK) SREQ <= 1'b0;
		cyc(4);
		m = 7'h10;
		`CMP({st, GPIO}, {m, 1'b1});
		@(posedge CLK) JREQ <= 1'b1;
		@(posedge CLK) JREQ <= 1'b0;
		#1 `CMP(GJ, 1'b1);
		@(posedge CLK) REL <= 1'b1;
		PERSIST <= 1'b1;
		@(posedge CLK) REL <= 1'b0;
		SREQ <= 1'b1;
		@(posedge CLK) SREQ <= 1'b0;
		#1 m = 7'h14;
		`CMP({st, GPIO}, {m, 1'b0});
		prog(4'h6);
		`CMP(CLR, 1'b1);
		wait_cd();
		@(posedge CLK) JREQ <= 1'b1;
		@(posedge CLK) JREQ <= 1'b0;
		prog(4'h6);
		`CMP(CLR, 1'b1);
		wait_cd();
		m = 7'h20;
		`CMP(st, m);
		complete_run();
	end
endmodule
